// ---- core/sar_core.sv ----
// sar conversion control top: sequencing, coding, saturation, config capture
// assumes comparator answer arrives within one ref_clk of the trial word
`timescale 1ns/100ps
`default_nettype none
`include "sar_params.svh"
module sar_core #(
  parameter int WIDTH  = `SAR_BITS,
  parameter int CWIDTH = `SAR_CFG_BITS
) (
  input  wire logic              ref_clk,     // internal conversion clock
  input  wire logic              rst_n,       // async reset, active low
  input  wire logic              conv_start,  // conversion_start_input pin
  input  wire logic              cmp_hi,      // comparator: input above trial
  input  wire logic              over_rng,    // front end reports over-range
  input  wire logic              under_rng,   // front end reports under-range
  input  wire logic              sclk,        // serial link clock
  input  wire logic              sdi,         // serial config in
  output logic                   sdo_q,       // serial out, registered on sclk
  output logic                   sample_q,    // 1 while tracking input
  output logic                   wake_q,      // analog powered
  output logic [WIDTH-1:0]       trial_q,     // dac trial word
  output logic [WIDTH-1:0]       result_q,    // last completed code
  output logic [CWIDTH-1:0]      cfg_q,       // active configuration
  output logic                   busy_q,      // conversion in progress
  output logic                   done_q       // one pulse per finished code
);
  sar_pkg::conv_state_type state_q;
  logic [2:0]        cnv_sync_q;
  logic              cnv_prev_q;
  logic [4:0]        bit_q;
  logic [WIDTH-1:0]  raw_q;
  logic [CWIDTH-1:0] cfg_used_q;
  logic [2:0]        tgl_sync_q;
  logic              tgl_prev_q;
  logic              cnv_lvl;
  logic              start_edge;
  logic              frame_n;
  logic              link_sdo;
  logic              busy_link;
  logic [CWIDTH-1:0] cfg_rx;
  logic              cfg_tgl;
  logic              cfg_take;
  logic [WIDTH-1:0]  code_d;
  sar_pkg::coding_type coding;

  // three stage sync; change accepted when stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnv_sync_q <= 3'h0;
    else cnv_sync_q <= {cnv_sync_q[1:0], conv_start};
  end
  always_comb cnv_lvl = cnv_sync_q[2];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnv_prev_q <= 1'b0;
    else if (cnv_sync_q[1] == cnv_sync_q[2]) cnv_prev_q <= cnv_lvl;
  end
  always_comb start_edge = (cnv_sync_q[1] == cnv_sync_q[2]) && cnv_lvl && !cnv_prev_q;

  // coding choice from input configuration field
  always_comb begin
    case (cfg_used_q[`SAR_CFG_INCC_HI:`SAR_CFG_INCC_LO])
      3'b111, 3'b110, 3'b100, 3'b101: coding = sar_pkg::CODE_BINARY;
      default:                        coding = sar_pkg::CODE_TWOS;
    endcase
  end

  // raw is straight binary; twos complement flips the msb, saturates by range
  always_comb begin
    code_d = raw_q;
    if (over_rng) code_d = `SAR_UNI_MAX;
    else if (under_rng) code_d = `SAR_UNI_MIN;
    if (coding == sar_pkg::CODE_TWOS) code_d = code_d ^ `SAR_UNI_MID;
  end

  // conversion sequencer on internal clock only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= sar_pkg::ST_SLEEP;
      bit_q   <= 5'h00;
      trial_q <= '0;
      raw_q   <= '0;
    end else begin
      case (state_q)
        sar_pkg::ST_SLEEP: begin
          if (start_edge) begin
            state_q <= sar_pkg::ST_CONV;
            bit_q   <= 5'(WIDTH - 1);
            trial_q <= `SAR_UNI_MID;
            raw_q   <= '0;
          end
        end
        sar_pkg::ST_CONV: begin
          raw_q[bit_q[3:0]] <= cmp_hi;
          if (bit_q == 5'h00) begin
            state_q <= sar_pkg::ST_DONE;
          end else begin
            bit_q   <= bit_q - 5'h01;
            trial_q <= (trial_q & ~(WIDTH'(!cmp_hi) << bit_q[3:0])) | (WIDTH'(1) << (bit_q[3:0] - 4'h1));
          end
        end
        sar_pkg::ST_DONE: begin
          state_q <= sar_pkg::ST_SLEEP;
          trial_q <= '0;
        end
        default: state_q <= sar_pkg::ST_SLEEP;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
      done_q   <= 1'b0;
    end else begin
      done_q <= (state_q == sar_pkg::ST_DONE);
      if (state_q == sar_pkg::ST_DONE) result_q <= code_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q   <= 1'b0;
      sample_q <= 1'b1;
      wake_q   <= 1'b0;
    end else begin
      busy_q   <= (state_q == sar_pkg::ST_CONV) || (state_q == sar_pkg::ST_SLEEP && start_edge);
      sample_q <= !(state_q == sar_pkg::ST_CONV || start_edge);
      wake_q   <= (state_q != sar_pkg::ST_SLEEP) || start_edge;
    end
  end

  // configuration word crosses by toggle; applies to the next conversion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) tgl_sync_q <= 3'h0;
    else tgl_sync_q <= {tgl_sync_q[1:0], cfg_tgl};
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) tgl_prev_q <= 1'b0;
    else if (tgl_sync_q[1] == tgl_sync_q[2]) tgl_prev_q <= tgl_sync_q[2];
  end
  always_comb cfg_take = (tgl_sync_q[1] == tgl_sync_q[2]) && (tgl_sync_q[2] != tgl_prev_q);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cfg_q <= `SAR_CFG_RESET;
    else if (cfg_take) cfg_q <= cfg_rx;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cfg_used_q <= `SAR_CFG_RESET;
    else if (state_q == sar_pkg::ST_SLEEP && start_edge) cfg_used_q <= cfg_q;
  end

  // the start pin doubles as frame: low frames a read; busy level is quasi static
  always_comb frame_n = conv_start;
  always_comb busy_link = busy_q;

  sar_link #(.WIDTH(WIDTH), .CWIDTH(CWIDTH)) u_link (
    .sclk      (sclk),
    .rst_n     (rst_n),
    .frame_n   (frame_n),
    .sdi       (sdi),
    .load_word (result_q),
    .load_cfg  (cfg_used_q),
    .busy_flag (busy_link),
    .sdo       (link_sdo),
    .cfg_shift (cfg_rx),
    .cfg_tgl   (cfg_tgl)
  );

  // sdo retimed on falling sclk so host samples on rising edge
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) sdo_q <= 1'b0;
    else sdo_q <= link_sdo;
  end

  // helper counters: long runs are counted here rather than unrolled in a property
  logic [4:0] conv_steps_q;
  logic [4:0] busy_run_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) conv_steps_q <= 5'h00;
    else if (state_q == sar_pkg::ST_CONV) conv_steps_q <= conv_steps_q + 5'h01;
    else conv_steps_q <= 5'h00;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) busy_run_q <= 5'h00;
    else if (busy_q) busy_run_q <= busy_run_q + 5'h01;
    else busy_run_q <= 5'h00;
  end

  // sequencing
  AST_SIXTEEN_STEPS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE) |-> (conv_steps_q == 5'h10))
    else $error("conversion did not take sixteen steps");
  AST_CONV_SPAN: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_SLEEP && start_edge) |-> ##17 (state_q == sar_pkg::ST_DONE))
    else $error("decisions did not end on time");
  AST_MSB_FIRST: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_SLEEP && start_edge) |=> (trial_q == `SAR_UNI_MID && bit_q == 5'h0F))
    else $error("first trial is not the top bit");
  AST_TRIAL_BIT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_CONV) |-> trial_q[bit_q[3:0]])
    else $error("trial word lacks the bit under decision");
  AST_KEEP_BIT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_CONV) |=> (raw_q[$past(bit_q[3:0])] == $past(cmp_hi)))
    else $error("decided bit does not follow the comparator");
  AST_BIT_STEP: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_CONV && bit_q != 5'h00) |=> (state_q == sar_pkg::ST_CONV && bit_q == $past(bit_q) - 5'h01))
    else $error("bit decisions not one at a time downward");
  AST_LSB_LAST: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_CONV && bit_q == 5'h00) |=> (state_q == sar_pkg::ST_DONE))
    else $error("conversion did not end after the last bit");
  AST_ONE_START: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    start_edge |=> !start_edge)
    else $error("one start edge seen twice");
  AST_START_BUSY: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_SLEEP && start_edge) |=> busy_q && !sample_q)
    else $error("start edge did not begin conversion");
  AST_SAMPLE_CONV: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_CONV) |-> !sample_q)
    else $error("tracking while converting");
  AST_BACK_TO_ACQ: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE) |=> sample_q && !busy_q && done_q)
    else $error("no return to acquisition after conversion");
  AST_BUSY_SPAN: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(busy_q) |-> (busy_run_q == 5'h11))
    else $error("busy did not stand seventeen cycles");
  AST_DONE_PULSE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    done_q |=> !done_q)
    else $error("done longer than one cycle");
  AST_DONE_AFTER: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    done_q |-> ($past(state_q) == sar_pkg::ST_DONE))
    else $error("done without a finished conversion");
  AST_TRIAL_CLEAR: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE) |=> (trial_q == '0))
    else $error("trial word not released after conversion");
  AST_WAKE_CONV: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_CONV) |-> wake_q)
    else $error("asleep while converting");
  AST_SLEEP_IDLE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_SLEEP && !start_edge) [*2] |=> !wake_q)
    else $error("not asleep between conversions");
  AST_RATE_FITS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE) |-> (int'(conv_steps_q) + 2 <= `SAR_CYC_PER_CONV))
    else $error("conversion too long for the top rate");

  // result coding and saturation
  AST_RESULT_HOLD: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !done_q |-> $stable(result_q))
    else $error("result changed outside completion");
  AST_RESULT_SAME: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    done_q |-> (result_q == $past(code_d)))
    else $error("result not from the conversion just finished");
  AST_UNI_SAT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE && over_rng && coding == sar_pkg::CODE_BINARY) |=> result_q == `SAR_UNI_MAX)
    else $error("unipolar over-range not saturated");
  AST_BIP_OVER: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE && over_rng && coding == sar_pkg::CODE_TWOS) |=> result_q == `SAR_BIP_MAX)
    else $error("bipolar over-range not saturated");
  AST_UNI_UNDER: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE && under_rng && !over_rng && coding == sar_pkg::CODE_BINARY) |=> result_q == `SAR_UNI_MIN)
    else $error("unipolar under-range not saturated");
  AST_BIP_SAT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE && under_rng && !over_rng && coding == sar_pkg::CODE_TWOS) |=> result_q == `SAR_BIP_MIN)
    else $error("bipolar under-range not saturated");
  AST_TWOS_CODE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE && !over_rng && !under_rng && coding == sar_pkg::CODE_TWOS)
      |=> result_q == ($past(raw_q) ^ `SAR_UNI_MID))
    else $error("bipolar code not twos complement");
  AST_BIN_CODE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_DONE && !over_rng && !under_rng && coding == sar_pkg::CODE_BINARY)
      |=> result_q == $past(raw_q))
    else $error("unipolar code not straight binary");
  AST_CODING_MAP: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (coding == sar_pkg::CODE_BINARY) == cfg_used_q[`SAR_CFG_INCC_HI])
    else $error("coding does not follow the input configuration");

  // configuration capture
  AST_CFG_LATCH: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == sar_pkg::ST_SLEEP && start_edge) |=> (cfg_used_q == $past(cfg_q)))
    else $error("conversion did not take the active configuration");
  AST_CFG_STEADY: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q != sar_pkg::ST_SLEEP) |=> $stable(cfg_used_q))
    else $error("configuration of a conversion changed under it");
  AST_CFG_TAKE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cfg_take |=> (cfg_q == $past(cfg_rx)))
    else $error("received configuration word not applied");
endmodule : sar_core
`default_nettype wire

// ---- core/sar_link.sv ----
// serial link end: shifts result out, configuration in, on the link clock
// assumes sclk is idle between frames and frame_n frames each word
`timescale 1ns/100ps
`default_nettype none
`include "sar_params.svh"
module sar_link #(
  parameter int WIDTH  = `SAR_BITS,
  parameter int CWIDTH = `SAR_CFG_BITS
) (
  input  wire logic              sclk,        // link clock from host
  input  wire logic              rst_n,       // async reset, active low
  input  wire logic              frame_n,     // active low frame, async to sclk
  input  wire logic              sdi,         // serial config in
  input  wire logic [WIDTH-1:0]  load_word,   // stable result in ref domain
  input  wire logic [CWIDTH-1:0] load_cfg,    // stable config word for readback
  input  wire logic              busy_flag,   // conversion busy (level)
  output logic                   sdo,         // serial data out
  output logic [CWIDTH-1:0]      cfg_shift,   // received config bits
  output logic                   cfg_tgl      // toggles when a full word received
);
  localparam int TOT = WIDTH + CWIDTH;
  logic [TOT-1:0] out_sh;
  logic [5:0]     cnt;
  logic           first;
  // words are quasi static while framed; host obeys conversion spacing
  always_ff @(posedge sclk or posedge frame_n) begin
    if (frame_n) begin
      cnt   <= 6'h00;
      first <= 1'b1;
      out_sh <= '0;
    end else begin
      first <= 1'b0;
      // busy is quasi static while framed, so sampling it on sclk is safe
      if (first) out_sh <= {busy_flag ? 1'b0 : load_word[WIDTH-1], load_word[WIDTH-2:0], load_cfg};
      else out_sh <= out_sh << 1;
      if (cnt != 6'h3F) cnt <= cnt + 6'h01;
    end
  end
  always_ff @(posedge sclk or posedge frame_n) begin
    if (frame_n) cfg_shift <= '0;
    else if (cnt < 6'(CWIDTH)) cfg_shift <= {cfg_shift[CWIDTH-2:0], sdi};
  end
  // toggle survives frame ends; only the system reset gives it a known level
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) cfg_tgl <= 1'b0;
    else if (cnt == 6'(CWIDTH - 1)) cfg_tgl <= ~cfg_tgl;
  end
  // first bit is loaded on the first rising sclk so the first falling edge shows it
  always_comb sdo = out_sh[TOT-1];
endmodule : sar_link
`default_nettype wire

// ---- core/sar_params.svh ----
// constants of the sar conversion control block
// assumes inclusion by bare name from core files
// Contract
// - host raises start after acquisition; rising edge begins conversion on held sample
// - sixteen binary-weighted decisions, most significant bit first, one per step
// - after decisions return to acquisition, form output code, show busy
// - conversion timed by internal clock, serial clock never needed
// - unipolar input configurations give straight binary codes
// - bipolar input configurations give twos complement codes
// - midscale gives 0x8000 unipolar or 0x0000 bipolar, plus one step adds one
// - over-range saturates at 0xFFFF unipolar or 0x7FFF bipolar
// - under-range saturates at 0x0000 unipolar or 0x8000 bipolar
// - fourteen-bit configuration word written serially sets all options (only bits 12 to 10, the coding choice, take effect here)
// - result readable after or during next conversion, config optionally appended (the link always appends it)
// - result belongs to the conversion just finished, no latency
// - up to 250 kSPS, low power between conversions, wake on start
// - start held low during conversion enables busy indication on serial output
// - result shifted out msb first on serial clock, config shifted in likewise
// - config bits 12 to 10 choose coding: 111,110,10X unipolar; 010,00X bipolar
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define SAR_BITS          16
`define SAR_CFG_BITS      14
`define SAR_CFG_INCC_HI   12
`define SAR_CFG_INCC_LO   10
`define SAR_CFG_RESET     14'h3_FFF
`define SAR_UNI_MID       16'h8000
`define SAR_UNI_MAX       16'hFFFF
`define SAR_UNI_MIN       16'h0000
`define SAR_BIP_MAX       16'h7FFF
`define SAR_BIP_MIN       16'h8000
`define SAR_CLK_NS        100
`define SAR_MIN_RATE_NS   4000
`define SAR_CYC_PER_CONV  ((`SAR_MIN_RATE_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`endif

// ---- core/sar_pkg.sv ----
// types of the sar conversion control block
// assumes sar_params.svh is on the include path
package sar_pkg;
  typedef enum logic [1:0] {ST_SLEEP, ST_CONV, ST_DONE} conv_state_type;
  typedef enum logic [0:0] {CODE_BINARY, CODE_TWOS} coding_type;
endpackage : sar_pkg

// ---- testbench/sar_conversion_and_output_coding_test.sv ----
// self-checking bench for the sar conversion control block
// assumes sar_core with default widths and the sar_host model
`timescale 1ns/100ps
`default_nettype none
module sar_conversion_and_output_coding_test;
  logic        ref_clk, rst_n, cmp_hi, over_rng, under_rng;
  logic        sdo_q, sample_q, wake_q, busy_q, done_q;
  logic [15:0] trial_q, result_q, target;
  logic [13:0] cfg_q, cur_cfg;
  wire logic   conv_start, sclk, sdi;
  int          errors, n_tests, cycles;

  sar_core sar_core_i (.ref_clk(ref_clk), .rst_n(rst_n), .conv_start(conv_start), .cmp_hi(cmp_hi),
    .over_rng(over_rng), .under_rng(under_rng), .sclk(sclk), .sdi(sdi), .sdo_q(sdo_q),
    .sample_q(sample_q), .wake_q(wake_q), .trial_q(trial_q), .result_q(result_q), .cfg_q(cfg_q),
    .busy_q(busy_q), .done_q(done_q));
  sar_host sar_host_i (.conv_start(conv_start), .sclk(sclk), .sdi(sdi), .sdo(sdo_q));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // comparator: keep the trial bit when the held input reaches it
  always @(negedge ref_clk) cmp_hi <= (target >= trial_q);
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("BAD %0t run exceeded cycle ceiling", $time);
      report_and_stop();
    end
  end

  task automatic chk_word(input logic [29:0] got, input logic [29:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // one conversion with no link activity; called at a falling ref_clk edge
  task automatic convert(input logic [15:0] tgt, input logic ov, input logic un, input logic [15:0] exp);
    logic [15:0] prev;
    int          k;
    prev      = result_q;
    target    = tgt;
    over_rng  = ov;
    under_rng = un;
    sar_host_i.start();
    k = 0;
    while (busy_q !== 1'b1 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    chk_bit(busy_q, 1'b1, "busy after start");
    chk_bit(sample_q, 1'b0, "tracking during conversion");
    chk_bit(wake_q, 1'b1, "awake during conversion");
    chk_word(30'(result_q), 30'(prev), "result held during conversion");
    k = 0;
    while (done_q !== 1'b1 && k < 60) begin
      @(negedge ref_clk);
      k++;
    end
    chk_word(30'(k), 30'd17, "cycles from busy to done");
    chk_word(30'(result_q), 30'(exp), "result code");
    chk_bit(busy_q, 1'b0, "busy after done");
    chk_bit(sample_q, 1'b1, "acquiring after done");
    over_rng  = 1'b0;
    under_rng = 1'b0;
    @(negedge ref_clk);
    chk_bit(done_q, 1'b0, "done is one pulse");
  endtask : convert

  task automatic t_reset();
    chk_word(30'(cfg_q), 30'h0000_3FFF, "config reset");
    chk_bit(busy_q, 1'b0, "busy reset");
    chk_bit(done_q, 1'b0, "done reset");
    chk_bit(sample_q, 1'b1, "tracking reset");
  endtask : t_reset

  task automatic t_unipolar();
    convert(16'h8000, 1'b0, 1'b0, 16'h8000);
    convert(16'h8001, 1'b0, 1'b0, 16'h8001);
    convert(16'h5A3C, 1'b0, 1'b0, 16'h5A3C);
    convert(16'h5A3C, 1'b1, 1'b0, 16'hFFFF);
    convert(16'h5A3C, 1'b0, 1'b1, 16'h0000);
    convert(16'h0001, 1'b1, 1'b1, 16'hFFFF);
  endtask : t_unipolar

  // each frame reads the last code with its config and writes the next mode
  task automatic t_modes();
    logic [2:0]  modes [7];
    logic [29:0] got;
    logic        bip;
    modes = '{3'b111, 3'b110, 3'b100, 3'b101, 3'b010, 3'b000, 3'b001};
    cur_cfg = 14'h3FFF;
    foreach (modes[m]) begin
      sar_host_i.frame({1'b1, modes[m], 10'h3FF}, got);
      chk_word(got, {result_q, cur_cfg}, "serial frame");
      cur_cfg = {1'b1, modes[m], 10'h3FF};
      bip = ~modes[m][2];
      repeat (10) @(negedge ref_clk);
      chk_word(30'(cfg_q), 30'(cur_cfg), "config applied");
      convert(16'h8000, 1'b0, 1'b0, bip ? 16'h0000 : 16'h8000);
      convert(16'h8001, 1'b0, 1'b0, bip ? 16'h0001 : 16'h8001);
      convert(16'hC3A5, 1'b1, 1'b0, bip ? 16'h7FFF : 16'hFFFF);
      convert(16'h3C5A, 1'b0, 1'b1, bip ? 16'h8000 : 16'h0000);
      convert(16'h3C5A, 1'b0, 1'b0, bip ? 16'hBC5A : 16'h3C5A);
    end
  endtask : t_modes

  initial begin
    errors    = 0;
    n_tests   = 0;
    cycles    = 0;
    rst_n     = 1'b0;
    over_rng  = 1'b0;
    under_rng = 1'b0;
    target    = 16'h0000;
    repeat (16) @(negedge ref_clk);
    t_reset();
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_unipolar();
    t_modes();
    report_and_stop();
  end
endmodule : sar_conversion_and_output_coding_test
`default_nettype wire

// ---- testbench/sar_host.sv ----
// host model: drives the conversion_start_input and the serial link
// assumes the device frames reads while conversion_start_input is low
`timescale 1ns/100ps
`default_nettype none
module sar_host (
  output var logic  conv_start,  // conversion_start_input
  output var logic  sclk,        // link clock, idle low outside frames
  output var logic  sdi,         // config bits to the device
  input  wire logic sdo          // result bits from the device
);
  initial begin
    conv_start = 1'b0;
    sclk       = 1'b0;
    sdi        = 1'b0;
  end
  // callers wait for done plus acquisition before the next start
  task automatic start();
    conv_start = 1'b1;
    #300;
    conv_start = 1'b0;
  endtask : start
  // 64 ns link period, phase offset keeps it unrelated to ref_clk
  task automatic frame(input logic [13:0] cfg, output logic [29:0] got);
    #7;
    for (int i = 0; i < 30; i++) begin
      sdi = (i < 14) ? cfg[13-i] : ~sdi;
      #16 sclk = 1'b1;
      #32 sclk = 1'b0;
      #16 got[29-i] = sdo;
    end
    sdi = ~sdi;
  endtask : frame
endmodule : sar_host
`default_nettype wire
